// ===== hdl/adc_fmt_pkg.sv
// adc_fmt_pkg: constants shared by the result formatting block.
// assumes a single system clock domain; no software bus.
package adc_fmt_pkg;
   localparam int SAMPLE_W = 12;
   localparam int RESULT_W = 16;
   localparam int CTRL_JUSTIFY_BIT = 2;
   localparam int LEFT_SHIFT = RESULT_W - SAMPLE_W;
   localparam logic [1:0] RPT_1 = 2'h0;
   localparam logic [1:0] RPT_4 = 2'h1;
   localparam logic [1:0] RPT_8 = 2'h2;
   localparam logic [1:0] RPT_16 = 2'h3;
   localparam logic [1:0] RPT_RESET = RPT_1;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [4:0] COUNT_RESET = 5'h00;
   localparam logic [4:0] SERIES_LEN_1 = 5'h01;
   localparam logic [4:0] SERIES_LEN_4 = 5'h04;
   localparam logic [4:0] SERIES_LEN_8 = 5'h08;
   localparam logic [4:0] SERIES_LEN_16 = 5'h10;
endpackage

// ===== hdl/adc_result_format_accumulator.sv
// adc_result_format_accumulator: justifies or sums converter samples into
// a 16-bit result split over two readable bytes.
// assumes sample_valid is a one-cycle pulse from logic on sys_clk.
//
// Functional notes
// - repeat one: each 12-bit unsigned sample replaces the result
// - result split into upper and lower readable bytes
// - control bit 2 selects right (0) or left (1) justification of single samples; sums are always right-justified
// - full scale reads 0x0FFF right, 0xFFF0 left; mid left 0x8000
// - result bits not holding code or sum read as zero
// - repeat above one: result updated only after the last sample
// - sums of 4, 8 or 16 samples, chosen by the repeat field
// - full-scale sums read 0x3FFC, 0x7FF8, 0xFFF0
`timescale 1ns/1ps
module adc_result_format_accumulator
   import adc_fmt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] converter_control_reg,
   input wire logic [1:0] repeat_count_field,
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] sample_code,
   output logic [7:0] result_high_byte,
   output logic [7:0] result_low_byte,
   output logic result_update
);
   logic left_justify_select;
   logic [15:0] result_reg, result_next;
   logic [15:0] acc_reg, acc_next;
   logic [4:0] count_reg, count_next;
   logic [1:0] rpt_reg, rpt_next;
   logic update_reg, update_next;

   // series length from the repeat field
   function automatic logic [4:0] series_len(input logic [1:0] f);
      logic [4:0] n;
      n = SERIES_LEN_1;
      case (f)
         RPT_4: n = SERIES_LEN_4;
         RPT_8: n = SERIES_LEN_8;
         RPT_16: n = SERIES_LEN_16;
         default: n = SERIES_LEN_1;
      endcase
      return n;
   endfunction

   // a code zero-extended to the result width, right-justified
   function automatic logic [15:0] zext_code(input logic [SAMPLE_W-1:0] c);
      return {{LEFT_SHIFT{1'b0}}, c};
   endfunction

   assign left_justify_select = converter_control_reg[CTRL_JUSTIFY_BIT];

   always_comb begin
      result_next = result_reg;
      acc_next = acc_reg;
      count_next = count_reg;
      rpt_next = rpt_reg;
      update_next = 1'b0;
      if (sample_valid) begin
         // repeat field is latched at series start so a mid-series change
         // cannot cut a sum short
         if (count_reg == COUNT_RESET) begin
            rpt_next = repeat_count_field;
         end
         if ((count_reg == COUNT_RESET ? repeat_count_field : rpt_reg)
             == RPT_1) begin
            // unused bits are zero by zero-extension
            if (left_justify_select) begin
               result_next = {sample_code, {LEFT_SHIFT{1'b0}}};
            end else begin
               result_next = zext_code(sample_code);
            end
            update_next = 1'b1;
            count_next = COUNT_RESET;
            acc_next = RESULT_RESET;
         end else begin
            // first sample starts from zero rather than the old sum
            if (count_reg == COUNT_RESET) begin
               acc_next = zext_code(sample_code);
            end else begin
               acc_next = acc_reg + zext_code(sample_code);
            end
            count_next = count_reg + 5'h01;
            // 16 x 0xFFF = 0xFFF0 fits, so no overflow is possible
            if (count_next == series_len(rpt_next)) begin
               result_next = acc_next; // right-justified only
               update_next = 1'b1;
               count_next = COUNT_RESET;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= RESULT_RESET;
         acc_reg <= RESULT_RESET;
         count_reg <= COUNT_RESET;
         rpt_reg <= RPT_RESET;
         update_reg <= 1'b0;
      end else begin
         result_reg <= result_next;
         acc_reg <= acc_next;
         count_reg <= count_next;
         rpt_reg <= rpt_next;
         update_reg <= update_next;
      end
   end

   // check-only state: every sample of the series so far was full scale;
   // no output depends on it, so synthesis drops it
   logic all_full_reg, all_full_next;

   always_comb begin
      all_full_next = all_full_reg;
      if (sample_valid) begin
         if (count_reg == COUNT_RESET) begin
            all_full_next = (sample_code == 12'hFFF);
         end else begin
            all_full_next = all_full_reg && (sample_code == 12'hFFF);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         all_full_reg <= 1'b0;
      end else begin
         all_full_reg <= all_full_next;
      end
   end

   assign result_high_byte = result_reg[15:8];
   assign result_low_byte = result_reg[7:0];
   assign result_update = update_reg;

   AST_SINGLE_RIGHT: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == COUNT_RESET && repeat_count_field == RPT_1
      && !left_justify_select |=> result_reg == {4'h0, $past(sample_code)})
      else $error("single right-justified result wrong");
   AST_SINGLE_LEFT: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == COUNT_RESET && repeat_count_field == RPT_1
      && left_justify_select |=> result_reg == {$past(sample_code), 4'h0})
      else $error("single left-justified result wrong");
   AST_SINGLE_UPDATE: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == COUNT_RESET && repeat_count_field == RPT_1
      |=> update_reg)
      else $error("single sample gave no update");
   AST_FULL_RIGHT: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == COUNT_RESET && repeat_count_field == RPT_1
      && !left_justify_select && sample_code == 12'hFFF
      |=> {result_high_byte, result_low_byte} == 16'h0FFF)
      else $error("full-scale right value wrong");
   AST_FULL_LEFT: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == COUNT_RESET && repeat_count_field == RPT_1
      && left_justify_select && sample_code == 12'hFFF
      |=> {result_high_byte, result_low_byte} == 16'hFFF0)
      else $error("full-scale left value wrong");
   AST_MID_LEFT: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == COUNT_RESET && repeat_count_field == RPT_1
      && left_justify_select && sample_code == 12'h800
      |=> {result_high_byte, result_low_byte} == 16'h8000)
      else $error("mid-scale left value wrong");
   AST_BYTES: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == COUNT_RESET && repeat_count_field == RPT_1
      && !left_justify_select
      |=> result_high_byte == {4'h0, $past(sample_code[11:8])}
      && result_low_byte == $past(sample_code[7:0]))
      else $error("result bytes do not split the result");
   AST_ZERO_BITS: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      update_reg && rpt_reg == RPT_1 |->
      result_reg[15:12] == 4'h0 || result_reg[3:0] == 4'h0)
      else $error("unused result bits not zero");
   AST_SUM4_BITS: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      update_reg && rpt_reg == RPT_4 |-> result_reg[15:14] == 2'h0)
      else $error("unused bits of a four-sample sum not zero");
   AST_SUM8_BITS: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      update_reg && rpt_reg == RPT_8 |-> !result_reg[15])
      else $error("unused bit of an eight-sample sum not zero");
   AST_HOLD: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !update_reg |-> result_reg == $past(result_reg))
      else $error("result changed without an update");
   AST_NO_EARLY: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg != COUNT_RESET
      && count_reg + 5'h01 != series_len(rpt_reg) |=> !update_reg)
      else $error("result updated before the series ended");
   AST_COUNT: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      count_reg < series_len(rpt_reg) || count_reg == COUNT_RESET)
      else $error("series count out of range");
   AST_LATCH: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !(sample_valid && count_reg == COUNT_RESET) |=> $stable(rpt_reg))
      else $error("repeat count changed inside a series");
   AST_FOUR: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == 5'h03 && rpt_reg == RPT_4
      |=> update_reg && result_reg == $past(acc_reg)
      + {4'h0, $past(sample_code)})
      else $error("four-sample sum wrong");
   AST_FULL_FOUR: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      update_reg && all_full_reg && rpt_reg == RPT_4
      |-> result_reg == 16'h3FFC)
      else $error("full-scale four-sample sum wrong");
   AST_FULL_EIGHT: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      update_reg && all_full_reg && rpt_reg == RPT_8
      |-> result_reg == 16'h7FF8)
      else $error("full-scale eight-sample sum wrong");
   AST_FULL_SIXTEEN: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      update_reg && all_full_reg && rpt_reg == RPT_16
      |-> result_reg == 16'hFFF0)
      else $error("full-scale sixteen-sample sum wrong");
   AST_CLEAR: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sample_valid && count_reg == COUNT_RESET && repeat_count_field != RPT_1
      |=> acc_reg == {4'h0, $past(sample_code)} && !update_reg)
      else $error("series did not start from zero");
endmodule

// ===== verification/adc_core_model.sv
// adc_core_model: stands in for the converter core handing out samples.
// assumes a request level from the bench, sampled on sys_clk.
`timescale 1ns/1ps
module adc_core_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [11:0] code_in,
   output logic sample_valid,
   output logic [11:0] sample_code
);
   // code inverts between samples so a stale value never passes for fresh
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_valid <= 1'b0;
         sample_code <= 12'h000;
      end else begin
         sample_valid <= start;
         sample_code <= start ? code_in : ~sample_code;
      end
   end
endmodule

// ===== verification/test_adc_result_format_accumulator.sv
// test_adc_result_format_accumulator: self-checking bench for the block.
// assumes the core model delivers one sample per requested cycle.
`timescale 1ns/1ps
module test_adc_result_format_accumulator;
   import adc_fmt_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, start = 1'b0, sample_valid, upd;
   logic [7:0] ctrl = 8'h00, hi, lo;
   logic [1:0] rpt = 2'h0;
   logic [11:0] code = 12'h000, sample_code;
   int errors = 0, checked = 0, updates = 0;
   always #5 sys_clk = ~sys_clk;
   // update pulses counted mid-cycle, where they are settled
   always @(negedge sys_clk) if (upd === 1'b1) updates++;
   adc_core_model adc_core_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .start(start), .code_in(code), .sample_valid(sample_valid),
      .sample_code(sample_code));
   adc_result_format_accumulator adc_result_format_accumulator_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .converter_control_reg(ctrl),
      .repeat_count_field(rpt), .sample_valid(sample_valid),
      .sample_code(sample_code), .result_high_byte(hi),
      .result_low_byte(lo), .result_update(upd));
   task check(input string what, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task give_verdict;
      if (errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // n back-to-back samples; the update comes once, one cycle after the
   // last sample, for one cycle, and the result then holds
   task run(input logic j, input logic [1:0] r, input int n,
            input logic [11:0] c, input logic [15:0] e);
      int k, u;
      @(posedge sys_clk);
      ctrl <= {5'h00, j, 2'h0};
      rpt <= r;
      u = updates;
      repeat (n) begin
         @(posedge sys_clk);
         start <= 1'b1;
         code <= c;
      end
      @(posedge sys_clk);
      start <= 1'b0;
      #1;
      k = 0;
      while (upd !== 1'b1 && k < 20) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      check("update", {15'h0000, upd}, 16'h0001);
      check("update delay", k[15:0], 16'h0001);
      check("result", {hi, lo}, e);
      @(posedge sys_clk);
      #1;
      check("update pulse", {15'h0000, upd}, 16'h0000);
      check("update count", 16'(updates - u), 16'h0001);
      check("result held", {hi, lo}, e);
   endtask
   task sc_single;
      logic [11:0] t[4];
      t = '{12'hFFF, 12'h800, 12'h7FF, 12'h000};
      foreach (t[i]) begin
         run(1'b0, RPT_1, 1, t[i], {4'h0, t[i]});
         run(1'b1, RPT_1, 1, t[i], {t[i], 4'h0});
      end
   endtask
   // series run back to back, so a missed clear shows as a wrong sum;
   // the justify bit stays clear for every sum
   task sc_sums;
      for (int r = 1; r < 4; r++) begin
         run(1'b0, r[1:0], 1 << (r + 1), 12'hFFF,
             16'hFFF << (r + 1));
         run(1'b0, r[1:0], 1 << (r + 1), 12'h7FF,
             16'h7FF << (r + 1));
         run(1'b0, r[1:0], 1 << (r + 1), 12'h800,
             16'h800 << (r + 1));
      end
   endtask
   // a repeat change inside a series only applies to the next series
   task sc_latch;
      int u;
      @(posedge sys_clk);
      ctrl <= 8'h00;
      rpt <= RPT_4;
      u = updates;
      repeat (4) begin
         @(posedge sys_clk);
         start <= 1'b1;
         code <= 12'h100;
      end
      rpt <= RPT_16;
      @(posedge sys_clk);
      start <= 1'b0;
      @(posedge sys_clk);
      #1;
      check("latched update", {15'h0000, upd}, 16'h0001);
      check("latched sum", {hi, lo}, 16'h0400);
      @(posedge sys_clk);
      #1;
      check("latched count", 16'(updates - u), 16'h0001);
      run(1'b0, RPT_16, 16, 12'h100, 16'h1000);
   endtask
   // reset inside a series: the next series counts from scratch
   task sc_reset;
      @(posedge sys_clk);
      rpt <= RPT_4;
      repeat (2) begin
         @(posedge sys_clk);
         start <= 1'b1;
         code <= 12'h123;
      end
      @(posedge sys_clk);
      start <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      check("reset result", {hi, lo}, RESULT_RESET);
      check("reset update", {15'h0000, upd}, 16'h0000);
      run(1'b0, RPT_4, 4, 12'h800, 16'h2000);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      check("after reset", {hi, lo}, RESULT_RESET);
      check("update after reset", {15'h0000, upd}, 16'h0000);
      run(1'b1, rpt, 1, 12'hABC, 16'hABC0);
      sc_single;
      sc_sums;
      sc_latch;
      sc_reset;
      give_verdict;
   end
   initial begin
      #100000;
      errors++;
      give_verdict;
   end
endmodule
